// ---- dv/sdhfr_card_model.sv ----
// sdhfr_card_model: engine and card side of the slice, worked by tasks from the bench
// assumes one caller at a time; released data lines show the inverse of the last value
module sdhfr_card_model
  import sdhfr_pkg::*;
(
  // clock
  input  wire logic        clock,
  // toward the slice
  output sdhfr_evt_t       evt,
  output logic             resp_push,
  output logic [15:0]      resp_data,
  output logic             rx_push,
  output logic [31:0]      rx_data,
  output logic             tx_pop,
  // from the slice
  input  wire logic [31:0] tx_data,
  input  wire logic        card_clock_stop
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    evt = '0;
    resp_push = 1'b0;
    resp_data = 16'h0;
    rx_push = 1'b0;
    rx_data = 32'h0;
    tx_pop = 1'b0;
  end
  task automatic pulse(input sdhfr_evt_t e);
    @(posedge clock);
    evt <= e;
    @(posedge clock);
    evt <= '0;
  endtask : pulse
  // crc already stripped, most significant half-word pushed first by the caller
  task automatic send_resp(input logic [15:0] h);
    @(posedge clock);
    resp_push <= 1'b1;
    resp_data <= h;
    @(posedge clock);
    resp_push <= 1'b0;
    resp_data <= ~h;
  endtask : send_resp
  // a stopped card clock holds the card off; a word pushed into a full fifo before the stop rises is dropped
  task automatic push_rx(input logic [31:0] d);
    @(posedge clock);
    while (card_clock_stop) @(posedge clock);
    rx_push <= 1'b1;
    rx_data <= d;
    @(posedge clock);
    rx_push <= 1'b0;
    rx_data <= ~d;
  endtask : push_rx
  task automatic pop_tx(output logic [31:0] d);
    @(posedge clock);
    tx_pop <= 1'b1;
    @(posedge clock);
    tx_pop <= 1'b0;
    @(negedge clock);
    d = tx_data;
  endtask : pop_tx
endmodule : sdhfr_card_model

// ---- dv/sdhfr_regs_sva.sv ----
// sdhfr_regs_chk: port-level assertions on the flag/fifo register slice
// assumes one clock domain; bound to sdhfr_regs from the bench top
module sdhfr_regs_chk
  import sdhfr_pkg::*;
(
  // clock and reset
  input wire logic        clock,
  input wire logic        arst_n,
  // register port
  input wire sdhfr_bus_t  bus,
  input wire logic [31:0] rdata,
  // engine side
  input wire sdhfr_evt_t  evt,
  input wire logic        sdio_irq,
  input wire logic        stream_mode,
  input wire logic        stop_sent,
  input wire logic        last_read_data,
  input wire logic        data_start,
  input wire logic        card_idle,
  input wire logic        resp_push,
  input wire logic [15:0] resp_data,
  input wire logic        rx_push,
  input wire logic [31:0] rx_data,
  input wire logic        tx_pop,
  input wire logic [31:0] tx_data,
  // status out
  input wire sdhfr_cfg_t  cfg,
  input wire logic        card_clock_stop,
  input wire logic        data_fifo_full,
  input wire logic        data_fifo_empty
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  logic flag_rd;
  assign flag_rd = bus.rd && bus.addr == SDHFR_OFS_FLAGS;

  rdata_idle_a: assert property (!bus.rd |=> rdata == 32'h0) else $error("read data not zero");
  fifo_excl_a: assert property (!(data_fifo_full && data_fifo_empty)) else $error("full and empty");
  fifo_mirror_a: assert property (flag_rd |=> rdata[14:13] == $past({data_fifo_full, data_fifo_empty}))
    else $error("fifo flags differ");
  sdio_mirror_a: assert property (flag_rd |=> rdata[7] == $past(sdio_irq)) else $error("card irq flag");
  reserved_zero_a: assert property (flag_rd |=> rdata[30:29] == 2'h0 && rdata[22:21] == 2'h0 &&
    rdata[4:3] == 2'h0) else $error("reserved flag bits set");
  cmd_store_a: assert property (bus.wr && bus.addr == SDHFR_OFS_CMD |=>
    cfg.cmd_index == $past(bus.wdata[5:0])) else $error("command index");
  arg_store_a: assert property (bus.wr && bus.addr == SDHFR_OFS_ARG |=>
    cfg.cmd_arg == $past(bus.wdata)) else $error("command argument");
  phase_store_a: assert property (bus.wr && bus.addr == SDHFR_OFS_LPC |=>
    {cfg.launch_edge_select, cfg.capture_edge_select, cfg.idle_clock_stop_enable} ==
    $past({bus.wdata[31:29], bus.wdata[0]})) else $error("phase select");
  align_gate_a: assert property (!cfg.byte_alignment_enable |-> cfg.start_address_low_bits == 2'h0)
    else $error("offset without alignment");
  start_empty_a: assert property (data_start |-> ##[1:2] data_fifo_empty) else $error("fifo not emptied");
endmodule : sdhfr_regs_chk

// ---- dv/tb_top.sv ----
// tb_top: self-checking bench for the sd host flag/fifo register slice
// assumes strobe register port, read data one cycle after the read strobe
module tb_top;
  import sdhfr_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] BASE = 32'h00002040;
  localparam int FB[19] = '{0, 1, 2, 8, 9, 10, 11, 12, 15, 16, 17, 18, 19, 20, 24, 25, 26, 27, 28};
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  sdhfr_bus_t bus = '0;
  logic sdio_irq = 1'b0, stream_mode = 1'b0, stop_sent = 1'b0;
  logic last_read_data = 1'b0, data_start = 1'b0, card_idle = 1'b0;
  logic [31:0] rdata, rx_data, tx_data, v;
  logic [15:0] resp_data;
  logic resp_push, rx_push, tx_pop, card_clock_stop, data_fifo_full, data_fifo_empty;
  sdhfr_evt_t evt;
  sdhfr_cfg_t cfg;
  int error_cnt = 0;
  int compares = 0;

  initial forever #50 clock = ~clock;

  sdhfr_regs DUT (.clock(clock), .arst_n(arst_n), .bus(bus), .rdata(rdata), .evt(evt), .sdio_irq(sdio_irq),
    .stream_mode(stream_mode), .stop_sent(stop_sent), .last_read_data(last_read_data), .data_start(data_start),
    .card_idle(card_idle), .resp_push(resp_push), .resp_data(resp_data), .rx_push(rx_push), .rx_data(rx_data),
    .tx_pop(tx_pop), .tx_data(tx_data), .cfg(cfg), .card_clock_stop(card_clock_stop),
    .data_fifo_full(data_fifo_full), .data_fifo_empty(data_fifo_empty));
  sdhfr_card_model u_card (.clock(clock), .evt(evt), .resp_push(resp_push), .resp_data(resp_data),
    .rx_push(rx_push), .rx_data(rx_data), .tx_pop(tx_pop), .tx_data(tx_data), .card_clock_stop(card_clock_stop));

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clock);
    bus <= '0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge clock);
    bus <= '0;
    @(negedge clock);
    d = rdata;
  endtask : rd
  // empties the data fifo and forgets the causes of the combined flags
  task automatic start_data;
    @(posedge clock);
    data_start <= 1'b1;
    @(posedge clock);
    data_start <= 1'b0;
  endtask : start_data
  task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    chk(what, d, exp);
  endtask : rchk
  task automatic t_reset;
    rchk("flags", SDHFR_OFS_FLAGS, BASE);
    rchk("arg", SDHFR_OFS_ARG, 32'h0);
    rchk("phase", SDHFR_OFS_LPC, 32'h0);
    rchk("dmac", SDHFR_OFS_DMAC, 32'h0);
    rchk("unmapped", 8'h60, 32'h0);
    $display("test reset done");
  endtask : t_reset
  task automatic t_sticky;
    sdhfr_evt_t e;
    for (int i = 0; i < 19; i++) begin
      e = '0;
      e[i] = 1'b1;
      // without a fresh start, earlier single events would also raise bits 31 and 23
      start_data();
      u_card.pulse(e);
      rchk("flag set", SDHFR_OFS_FLAGS, BASE | (32'h1 << FB[i]));
      wr(SDHFR_OFS_FLAGS, ~(32'h1 << FB[i]) & ~SDHFR_STICKY_MASK);
      rchk("flag kept", SDHFR_OFS_FLAGS, BASE | (32'h1 << FB[i]));
      wr(SDHFR_OFS_FLAGS, 32'h1 << FB[i]);
      rchk("flag clear", SDHFR_OFS_FLAGS, BASE);
    end
    $display("test sticky done");
  endtask : t_sticky
  task automatic t_combined;
    start_data();
    u_card.pulse('{xfer_done: 1'b1, default: '0});
    rchk("xfer only", SDHFR_OFS_FLAGS, BASE | 32'h1);
    u_card.pulse('{dma_end: 1'b1, default: '0});
    rchk("dma data done", SDHFR_OFS_FLAGS, BASE | 32'h80010001);
    u_card.pulse('{card_programming_complete_flag: 1'b1, default: '0});
    rchk("write all done", SDHFR_OFS_FLAGS, BASE | 32'h80810003);
    wr(SDHFR_OFS_FLAGS, 32'hffffffff);
    rchk("all clear", SDHFR_OFS_FLAGS, BASE);
    @(posedge clock) stream_mode <= 1'b1;
    u_card.pulse('{xfer_done: 1'b1, default: '0});
    rchk("stream early", SDHFR_OFS_FLAGS, BASE);
    @(posedge clock) stop_sent <= 1'b1;
    u_card.pulse('{xfer_done: 1'b1, default: '0});
    rchk("stream stopped", SDHFR_OFS_FLAGS, BASE | 32'h1);
    wr(SDHFR_OFS_FLAGS, 32'h1);
    {stream_mode, stop_sent, sdio_irq} <= 3'h1;
    wr(SDHFR_OFS_FLAGS, 32'h80);
    rchk("card irq", SDHFR_OFS_FLAGS, BASE | 32'h80);
    @(posedge clock) sdio_irq <= 1'b0;
    $display("test combined done");
  endtask : t_combined
  task automatic t_cfg;
    wr(SDHFR_OFS_CMD, 32'hffffffff);
    rchk("cmd index", SDHFR_OFS_CMD, 32'h3f);
    wr(SDHFR_OFS_ARG, 32'ha5c3e781);
    rchk("arg", SDHFR_OFS_ARG, 32'ha5c3e781);
    for (int s = 0; s < 3; s++) begin
      wr(SDHFR_OFS_LPC, {2'(s), 30'h3fffffff});
      rchk("phase", SDHFR_OFS_LPC, {2'(s), 30'h20000001});
    end
    @(posedge clock) card_idle <= 1'b1;
    repeat (3) @(posedge clock);
    @(negedge clock);
    chk("clock stop", {31'h0, card_clock_stop}, 32'h1);
    wr(SDHFR_OFS_LPC, 32'h0);
    // card still idle: with low power off the clock must keep running
    @(posedge clock);
    @(negedge clock);
    chk("clock run", {31'h0, card_clock_stop}, 32'h0);
    @(posedge clock) card_idle <= 1'b0;
    wr(SDHFR_OFS_DMAC, 32'hffffffe0);
    @(negedge clock);
    chk("offset gated", {30'h0, cfg.start_address_low_bits}, 32'h0);
    rchk("dmac", SDHFR_OFS_DMAC, 32'he0);
    wr(SDHFR_OFS_DMAC, 32'h70);
    @(negedge clock);
    chk("offset", {28'h0, cfg.length_mode, cfg.start_address_low_bits, cfg.byte_alignment_enable}, 32'h7);
    $display("test config done");
  endtask : t_cfg
  task automatic t_fifo;
    logic [31:0] d;
    for (int i = 0; i < 8; i++) u_card.send_resp(16'h1000 + 16'(i));
    for (int i = 0; i < 8; i++) rchk("resp", SDHFR_OFS_RESP, 32'h1000 + i);
    for (int i = 0; i < 129; i++) begin
      wr(SDHFR_OFS_TX, 32'h100 + i);
      if (i == 6) rchk("seven", SDHFR_OFS_FLAGS, 32'h40);
      if (i == 7) rchk("eight", SDHFR_OFS_FLAGS, 32'h20);
    end
    rchk("full", SDHFR_OFS_FLAGS, 32'h4020);
    for (int i = 0; i < 128; i++) begin
      u_card.pop_tx(d);
      chk("tx word", d, 32'h100 + i);
    end
    rchk("drained", SDHFR_OFS_FLAGS, BASE);
    for (int i = 0; i < 3; i++) u_card.push_rx(32'hc0 + i);
    rchk("few", SDHFR_OFS_FLAGS, 32'h40);
    @(posedge clock) last_read_data <= 1'b1;
    rchk("last data", SDHFR_OFS_FLAGS, 32'h60);
    for (int i = 0; i < 3; i++) rchk("rx word", SDHFR_OFS_RX, 32'hc0 + i);
    @(posedge clock) last_read_data <= 1'b0;
    $display("test fifo done");
  endtask : t_fifo
  task automatic conclude;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : conclude

  initial begin
    #2_000_000;
    error_cnt++;
    conclude();
  end
  initial begin
    repeat (8) @(posedge clock);
    arst_n <= 1'b1;
    t_reset();
    t_sticky();
    t_combined();
    t_cfg();
    t_fifo();
    conclude();
  end
endmodule : tb_top

bind sdhfr_regs sdhfr_regs_chk u_chk (.clock(clock), .arst_n(arst_n), .bus(bus), .rdata(rdata), .evt(evt),
  .sdio_irq(sdio_irq), .stream_mode(stream_mode), .stop_sent(stop_sent), .last_read_data(last_read_data),
  .data_start(data_start), .card_idle(card_idle), .resp_push(resp_push), .resp_data(resp_data),
  .rx_push(rx_push), .rx_data(rx_data), .tx_pop(tx_pop), .tx_data(tx_data), .cfg(cfg),
  .card_clock_stop(card_clock_stop), .data_fifo_full(data_fifo_full), .data_fifo_empty(data_fifo_empty));

// ---- rtl/sdhfr_pkg.sv ----
// sdhfr_pkg: register map, field positions and carrier types for the sd host flag/fifo register slice
// assumes a plain strobe register port with read data one cycle after the read strobe
package sdhfr_pkg;

  localparam logic [7:0] SDHFR_OFS_FLAGS = 8'h28;
  localparam logic [7:0] SDHFR_OFS_CMD   = 8'h2c;
  localparam logic [7:0] SDHFR_OFS_ARG   = 8'h30;
  localparam logic [7:0] SDHFR_OFS_RESP  = 8'h34;
  localparam logic [7:0] SDHFR_OFS_RX    = 8'h38;
  localparam logic [7:0] SDHFR_OFS_TX    = 8'h3c;
  localparam logic [7:0] SDHFR_OFS_LPC   = 8'h40;
  localparam logic [7:0] SDHFR_OFS_DMAC  = 8'h44;

  localparam int SDHFR_B_DMA_DATA_DONE = 31;
  localparam int SDHFR_B_PIN_LO        = 24;
  localparam int SDHFR_B_WR_ALL_DONE   = 23;
  localparam int SDHFR_B_BOOT_CRC      = 20;
  localparam int SDHFR_B_BOOT_END      = 19;
  localparam int SDHFR_B_BOOT_ACK_ERR  = 18;
  localparam int SDHFR_B_BOOT_ACK      = 17;
  localparam int SDHFR_B_DMA_END       = 16;
  localparam int SDHFR_B_AUTO_STOP     = 15;
  localparam int SDHFR_B_FIFO_FULL     = 14;
  localparam int SDHFR_B_FIFO_EMPTY    = 13;
  localparam int SDHFR_B_CRC_RESP      = 12;
  localparam int SDHFR_B_CRC_READ      = 11;
  localparam int SDHFR_B_CRC_WRITE     = 10;
  localparam int SDHFR_B_TO_RESP       = 9;
  localparam int SDHFR_B_TO_READ       = 8;
  localparam int SDHFR_B_SDIO          = 7;
  localparam int SDHFR_B_TX_REQ        = 6;
  localparam int SDHFR_B_RX_REQ        = 5;
  localparam int SDHFR_B_CMD_DONE      = 2;
  localparam int SDHFR_B_CARD_PROGRAMMING_COMPLETE_FLAG      = 1;
  localparam int SDHFR_B_XFER_DONE     = 0;

  // sticky write-one-to-clear bits (28:24, 20:15, 12:8, 2:0)
  localparam logic [31:0] SDHFR_W1C_MASK = 32'h1f1f9f07;
  // flags set by hardware events and cleared by software, incl. bits 31 and 23
  localparam logic [31:0] SDHFR_STICKY_MASK = 32'h9f9f9f07;

  localparam logic [31:0] SDHFR_LPC_MASK  = 32'he0000001;
  localparam logic [31:0] SDHFR_DMAC_MASK = 32'h000000ff;
  localparam logic [7:0]  SDHFR_CMD_MASK  = 8'h3f;

  localparam int SDHFR_LPC_DRV_HI = 31;
  localparam int SDHFR_LPC_DRV_LO = 30;
  localparam int SDHFR_LPC_SMP    = 29;
  localparam int SDHFR_LPC_LPM    = 0;
  localparam int SDHFR_DMAC_MODE  = 7;
  localparam int SDHFR_DMAC_OFS_HI = 6;
  localparam int SDHFR_DMAC_OFS_LO = 5;
  localparam int SDHFR_DMAC_ALIGN = 4;

  localparam int SDHFR_DATA_DEPTH = 128;
  localparam int SDHFR_DATA_AW    = 7;
  localparam int SDHFR_RESP_DEPTH = 8;
  localparam int SDHFR_RESP_AW    = 3;
  localparam logic [SDHFR_DATA_AW:0] SDHFR_HALF_MARK = 8'h08;
  localparam logic [SDHFR_DATA_AW:0] SDHFR_DATA_FULL = 8'h80;
  localparam logic [SDHFR_RESP_AW:0] SDHFR_RESP_FULL = 4'h8;

  localparam logic [31:0] SDHFR_RST_WORD = 32'h00000000;
  localparam logic [1:0]  SDHFR_DRV_FALL = 2'h0;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } sdhfr_bus_t;

  // one-cycle event pulses from the command/data engine
  typedef struct packed {
    logic [4:0] pin_level;
    logic       boot_crc;
    logic       boot_end;
    logic       boot_ack_err;
    logic       boot_ack;
    logic       dma_end;
    logic       auto_stop;
    logic       crc_resp;
    logic       crc_read;
    logic       crc_write;
    logic       to_resp;
    logic       to_read;
    logic       cmd_done;
    logic       card_programming_complete_flag;
    logic       xfer_done;
  } sdhfr_evt_t;

  typedef struct packed {
    logic [1:0]  launch_edge_select;
    logic        capture_edge_select;
    logic        idle_clock_stop_enable;
    logic        length_mode;
    logic [1:0]  start_address_low_bits;
    logic        byte_alignment_enable;
    logic [5:0]  cmd_index;
    logic [31:0] cmd_arg;
  } sdhfr_cfg_t;

endpackage : sdhfr_pkg

// ---- rtl/sdhfr_regs.sv ----
// sdhfr_regs: interrupt flag register, command registers, response fifo, shared data fifo, phase/dma config
// assumes engine events are single-cycle pulses synchronous to clock; card-clock gating itself is elsewhere
//
// The implementer's own choice: the address-and-strobe port.
module sdhfr_regs
  import sdhfr_pkg::*;
(
  // clock and reset
  input  wire logic             clock,
  input  wire logic             arst_n,
  // register port
  input  wire sdhfr_bus_t       bus,
  output logic [31:0]           rdata,
  // engine events and levels
  input  wire sdhfr_evt_t       evt,
  input  wire logic             sdio_irq,
  input  wire logic             stream_mode,
  input  wire logic             stop_sent,
  input  wire logic             last_read_data,
  input  wire logic             data_start,
  input  wire logic             card_idle,
  // response fifo fill from engine
  input  wire logic             resp_push,
  input  wire logic [15:0]      resp_data,
  // data fifo card side
  input  wire logic             rx_push,
  input  wire logic [31:0]      rx_data,
  input  wire logic             tx_pop,
  output logic [31:0]           tx_data,
  // configuration and status to engine
  output sdhfr_cfg_t            cfg,
  output logic                  card_clock_stop,
  output logic                  data_fifo_full,
  output logic                  data_fifo_empty
);

  typedef struct packed {
    logic [31:0]              flags;
    logic                     xfer_seen;
    logic                     dma_seen;
    logic                     prg_seen;
    sdhfr_cfg_t               cfg;
    logic [SDHFR_DATA_AW:0]   dcount;
    logic [SDHFR_DATA_AW-1:0] dwp;
    logic [SDHFR_DATA_AW-1:0] drp;
    logic [SDHFR_RESP_AW:0]   rcount;
    logic [SDHFR_RESP_AW-1:0] rwp;
    logic [SDHFR_RESP_AW-1:0] rrp;
    logic [31:0]              rdata;
    logic [31:0]              tx_data;
    logic                     clk_stop;
    logic                     full;
    logic                     empty;
  } sdhfr_state_t;

  sdhfr_state_t st;
  sdhfr_state_t next_st;

  // storage kept outside the state struct so the arrays infer as plain ram
  logic [31:0] data_mem [SDHFR_DATA_DEPTH];
  logic [15:0] resp_mem [SDHFR_RESP_DEPTH];

  function automatic logic hit(input sdhfr_bus_t b, input logic [7:0] ofs, input logic is_wr);
    hit = (is_wr ? b.wr : b.rd) && (b.addr == ofs);
  endfunction : hit

  logic wr_flags;
  logic wr_tx;
  logic rd_rx;
  logic rd_resp;
  logic do_tx;
  logic do_rx_pop;
  logic do_rx_push;
  logic do_tx_pop;
  logic do_resp_push;
  logic do_resp_pop;

  assign wr_flags    = hit(bus, SDHFR_OFS_FLAGS, 1'b1);
  assign wr_tx       = hit(bus, SDHFR_OFS_TX, 1'b1);
  assign rd_rx       = hit(bus, SDHFR_OFS_RX, 1'b0);
  assign rd_resp     = hit(bus, SDHFR_OFS_RESP, 1'b0);
  // one shared fifo: software fills it for transmit, card side fills it for receive
  assign do_tx       = wr_tx && (st.dcount != SDHFR_DATA_FULL) && !data_start;
  assign do_rx_push  = rx_push && (st.dcount != SDHFR_DATA_FULL) && !data_start;
  assign do_rx_pop   = rd_rx && (st.dcount != '0) && !data_start;
  assign do_tx_pop   = tx_pop && (st.dcount != '0) && !do_rx_pop && !data_start;
  assign do_resp_push = resp_push && (st.rcount != SDHFR_RESP_FULL);
  assign do_resp_pop  = rd_resp && (st.rcount != '0);

  always_comb begin
    logic [31:0] set_v;
    logic [31:0] clr_v;
    logic        xfer_now;
    logic        dma_now;
    logic        prg_now;
    logic [SDHFR_DATA_AW:0] cnt;
    next_st  = st;
    cnt      = st.dcount;
    set_v    = '0;
    clr_v    = '0;
    // in stream mode the transfer only counts as done once the stop command went out
    xfer_now = evt.xfer_done && (!stream_mode || stop_sent);
    dma_now  = evt.dma_end;
    prg_now  = evt.card_programming_complete_flag;

    set_v[SDHFR_B_PIN_LO +: 5]      = evt.pin_level;
    set_v[SDHFR_B_BOOT_CRC]         = evt.boot_crc;
    set_v[SDHFR_B_BOOT_END]         = evt.boot_end;
    set_v[SDHFR_B_BOOT_ACK_ERR]     = evt.boot_ack_err;
    set_v[SDHFR_B_BOOT_ACK]         = evt.boot_ack;
    set_v[SDHFR_B_DMA_END]          = dma_now;
    set_v[SDHFR_B_AUTO_STOP]        = evt.auto_stop;
    set_v[SDHFR_B_CRC_RESP]         = evt.crc_resp;
    set_v[SDHFR_B_CRC_READ]         = evt.crc_read;
    set_v[SDHFR_B_CRC_WRITE]        = evt.crc_write;
    set_v[SDHFR_B_TO_RESP]          = evt.to_resp;
    set_v[SDHFR_B_TO_READ]          = evt.to_read;
    set_v[SDHFR_B_CMD_DONE]         = evt.cmd_done;
    set_v[SDHFR_B_CARD_PROGRAMMING_COMPLETE_FLAG]         = prg_now;
    set_v[SDHFR_B_XFER_DONE]        = xfer_now;

    // combined flags track their causes since the last data start, as events can arrive apart
    next_st.xfer_seen = (st.xfer_seen || xfer_now) && !data_start;
    next_st.dma_seen  = (st.dma_seen || dma_now) && !data_start;
    next_st.prg_seen  = (st.prg_seen || prg_now) && !data_start;
    set_v[SDHFR_B_DMA_DATA_DONE] = (st.xfer_seen || xfer_now) && (st.dma_seen || dma_now)
                                   && !(st.xfer_seen && st.dma_seen);
    set_v[SDHFR_B_WR_ALL_DONE]   = (st.xfer_seen || xfer_now) && (st.dma_seen || dma_now)
                                   && (st.prg_seen || prg_now)
                                   && !(st.xfer_seen && st.dma_seen && st.prg_seen);

    if (wr_flags) begin
      // only ones in clearable positions act; zeros and read-only positions are ignored
      clr_v = bus.wdata & SDHFR_STICKY_MASK;
    end
    // set wins over a clear in the same cycle
    next_st.flags = ((st.flags & ~clr_v) | set_v) & SDHFR_STICKY_MASK;

    if (hit(bus, SDHFR_OFS_CMD, 1'b1)) begin
      next_st.cfg.cmd_index = bus.wdata[5:0];
    end
    if (hit(bus, SDHFR_OFS_ARG, 1'b1)) begin
      next_st.cfg.cmd_arg = bus.wdata;
    end
    if (hit(bus, SDHFR_OFS_LPC, 1'b1)) begin
      next_st.cfg.launch_edge_select     = bus.wdata[SDHFR_LPC_DRV_HI:SDHFR_LPC_DRV_LO];
      next_st.cfg.capture_edge_select    = bus.wdata[SDHFR_LPC_SMP];
      next_st.cfg.idle_clock_stop_enable = bus.wdata[SDHFR_LPC_LPM];
    end
    if (hit(bus, SDHFR_OFS_DMAC, 1'b1)) begin
      next_st.cfg.length_mode            = bus.wdata[SDHFR_DMAC_MODE];
      next_st.cfg.start_address_low_bits = bus.wdata[SDHFR_DMAC_OFS_HI:SDHFR_DMAC_OFS_LO];
      next_st.cfg.byte_alignment_enable  = bus.wdata[SDHFR_DMAC_ALIGN];
    end

    // starting a data command returns the data fifo to empty
    if (data_start) begin
      next_st.dwp = '0;
      next_st.drp = '0;
      cnt         = '0;
    end else begin
      if (do_tx || do_rx_push) begin
        next_st.dwp = st.dwp + 1'b1;
      end
      if (do_rx_pop || do_tx_pop) begin
        next_st.drp = st.drp + 1'b1;
      end
      if ((do_tx || do_rx_push) && !(do_rx_pop || do_tx_pop)) begin
        cnt = st.dcount + 1'b1;
      end else if (!(do_tx || do_rx_push) && (do_rx_pop || do_tx_pop)) begin
        cnt = st.dcount - 1'b1;
      end
    end
    next_st.dcount = cnt;
    next_st.full   = (cnt == SDHFR_DATA_FULL);
    next_st.empty  = (cnt == '0);

    if (do_resp_push) begin
      next_st.rwp = st.rwp + 1'b1;
    end
    if (do_resp_pop) begin
      next_st.rrp = st.rrp + 1'b1;
    end
    if (do_resp_push && !do_resp_pop) begin
      next_st.rcount = st.rcount + 1'b1;
    end else if (!do_resp_push && do_resp_pop) begin
      next_st.rcount = st.rcount - 1'b1;
    end

    if (do_tx_pop) begin
      next_st.tx_data = data_mem[st.drp];
    end

    // clock stops on an idle card while idle_clock_stop_enable is set; also paused when fifo would over- or under-run
    next_st.clk_stop = (st.cfg.idle_clock_stop_enable && card_idle)
                       || (rx_push && st.full) || (tx_pop && st.empty);

    next_st.rdata = '0;
    if (bus.rd) begin
      unique case (bus.addr)
        SDHFR_OFS_FLAGS: begin
          next_st.rdata = st.flags;
          next_st.rdata[SDHFR_B_FIFO_FULL]  = st.full;
          next_st.rdata[SDHFR_B_FIFO_EMPTY] = st.empty;
          next_st.rdata[SDHFR_B_SDIO]       = sdio_irq;
          next_st.rdata[SDHFR_B_TX_REQ]     = (st.dcount < SDHFR_HALF_MARK);
          next_st.rdata[SDHFR_B_RX_REQ]     = (st.dcount >= SDHFR_HALF_MARK)
                                              || (last_read_data && (st.dcount != '0));
        end
        SDHFR_OFS_CMD:  next_st.rdata = {24'h000000, 2'h0, st.cfg.cmd_index};
        SDHFR_OFS_ARG:  next_st.rdata = st.cfg.cmd_arg;
        SDHFR_OFS_RESP: next_st.rdata = {16'h0000, resp_mem[st.rrp]};
        SDHFR_OFS_RX:   next_st.rdata = data_mem[st.drp];
        SDHFR_OFS_LPC:  next_st.rdata = {st.cfg.launch_edge_select, st.cfg.capture_edge_select,
                                         28'h0000000, st.cfg.idle_clock_stop_enable};
        SDHFR_OFS_DMAC: next_st.rdata = {24'h000000, st.cfg.length_mode,
                                         st.cfg.start_address_low_bits, st.cfg.byte_alignment_enable,
                                         4'h0};
        default:        next_st.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st       <= '0;
      st.empty <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // memories carry no reset; pointers define what is valid
  always_ff @(posedge clock) begin
    if (do_tx) begin
      data_mem[st.dwp] <= bus.wdata;
    end else if (do_rx_push) begin
      data_mem[st.dwp] <= rx_data;
    end
    // engine pushes half-words high first and strips the crc before pushing
    if (do_resp_push) begin
      resp_mem[st.rwp] <= resp_data;
    end
  end

  // start address low bits only matter while byte alignment is on
  always_comb begin
    cfg = st.cfg;
    if (!st.cfg.byte_alignment_enable) begin
      cfg.start_address_low_bits = 2'h0;
    end
  end

  assign rdata           = st.rdata;
  assign tx_data         = st.tx_data;
  assign card_clock_stop = st.clk_stop;
  assign data_fifo_full  = st.full;
  assign data_fifo_empty = st.empty;

endmodule : sdhfr_regs
